// >>> core/clock_timer.sv
// Contract
// R1 - 8-bit up-counter advancing per 256 Hz tick
// R2 - counter bits readable by software
// R3 - tick is oscillator divided by 128, ungated
// R4 - clear bit 4 write clears counter
// R5 - system reset clears counter
// R6 - run bit 0 starts, zero stops holding
// R7 - run plus clear: clear then count
// R8 - start/stop act at next tick fall
// R9 - run reads 1 until stopped
// R10 - causes on 32/8/2/1 Hz tap falls
// R11 - disabled tap sets no flag
// R12 - flags at pending bits 3..0
// R13 - enables at enable bits 3..0
// R14 - one request while any flag set
// R15 - write 1 clears a flag
// R16 - software clears flags before enabling
// R17 - controller treats request as level
// R18 - software resets timer before starting
// R19 - serviced via vector 7, 0x801c
// R20 - clear while running keeps counting
// R21 - bit 7 is 1 Hz, bit 0 128 Hz
// R22 - clear bit reads 0, write 0 ignored
// R23 - tick used as enable, edge detected
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module clock_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // low-speed oscillator from a pin
    input wire logic i_low_speed_oscillator,
    // register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // tick out for observation
    output logic o_tick_256hz,
    // link
    clock_timer_if.device link
);
    typedef enum logic {STOPPED, COUNTING} run_state_type;

    typedef struct packed {
        logic osc_s1;
        logic osc_s2;
        logic osc_d;
        logic [6:0] div;
        logic tick;
        logic tick_d;
        logic run_req;
        run_state_type run_state;
        logic [7:0] count;
        logic [3:0] enable;
        logic [3:0] flags;
        logic irq;
        logic [7:0] rdata;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic tick_fall;
    logic count_step;
    logic [7:0] cnt_inc;
    logic [3:0] tap_fall;
    logic wr_ctl;
    logic wr_pnd;

    // R23 tick falling edge
    assign tick_fall = st_r.tick_d && !st_r.tick;
    // old run state decides, so a stop still counts once
    assign count_step = tick_fall && (st_r.run_state == COUNTING);
    assign cnt_inc = st_r.count + 8'd1;

    // R10 R21 per-tap falling edge
    for (genvar g = 0; g < 4; g++) begin : gen_tap
        localparam int POS = (g == 3) ? clock_timer_pkg::TAP_32HZ
            : (g == 2) ? clock_timer_pkg::TAP_8HZ
            : (g == 1) ? clock_timer_pkg::TAP_2HZ
            : clock_timer_pkg::TAP_1HZ;
        assign tap_fall[g] = count_step && st_r.count[POS] && !cnt_inc[POS];
    end

    always_comb begin
        st_nxt = st_r;
        wr_ctl = i_wr && (i_addr == clock_timer_pkg::CTL_ADDR);
        wr_pnd = i_wr && (i_addr == clock_timer_pkg::PND_ADDR);
        // oscillator pin synchronised, rising edges counted
        st_nxt.osc_s1 = i_low_speed_oscillator;
        st_nxt.osc_s2 = st_r.osc_s1;
        st_nxt.osc_d = st_r.osc_s2;
        // R3 divide by 128
        if (st_r.osc_s2 && !st_r.osc_d) begin
            st_nxt.div = st_r.div + 7'd1;
            if (st_r.div == 7'(clock_timer_pkg::TICK_DIVIDE / 2 - 1)) begin
                st_nxt.tick = 1'b0;
            end
            if (st_r.div == 7'(clock_timer_pkg::TICK_DIVIDE - 1)) begin
                st_nxt.tick = 1'b1;
            end
        end
        st_nxt.tick_d = st_r.tick;
        // R1 R8 run state taken on tick fall
        if (tick_fall) begin
            unique case (st_r.run_state)
                STOPPED: begin
                    if (st_r.run_req) begin
                        st_nxt.run_state = COUNTING;
                    end
                end
                COUNTING: begin
                    st_nxt.count = cnt_inc;
                    if (!st_r.run_req) begin
                        st_nxt.run_state = STOPPED;
                    end
                end
            endcase
        end
        // R6 R7 R22 control writes
        if (wr_ctl) begin
            st_nxt.run_req = i_wdata[clock_timer_pkg::RUN_BIT];
            // R4 R20 clear wins over increment
            if (i_wdata[clock_timer_pkg::CLEAR_BIT]) begin
                st_nxt.count = clock_timer_pkg::COUNT_RESET;
            end
        end
        // R13 enable register
        if (i_wr && (i_addr == clock_timer_pkg::ENA_ADDR)) begin
            st_nxt.enable = i_wdata[3:0];
        end
        // R15 write 1 clears; R11 R12 set wins
        if (wr_pnd) begin
            st_nxt.flags = st_r.flags & ~i_wdata[3:0];
        end
        st_nxt.flags = st_nxt.flags | (tap_fall & st_r.enable);
        // R14 level request
        st_nxt.irq = |st_nxt.flags;
        // R2 R9 read path
        st_nxt.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                clock_timer_pkg::CTL_ADDR: begin
                    // run reads 1 until the stop has really taken effect
                    st_nxt.rdata = {7'h00, st_r.run_req | (st_r.run_state == COUNTING)};
                end
                clock_timer_pkg::CNT_ADDR: st_nxt.rdata = st_r.count;
                clock_timer_pkg::ENA_ADDR: st_nxt.rdata = {4'h0, st_r.enable};
                clock_timer_pkg::PND_ADDR: st_nxt.rdata = {4'h0, st_r.flags};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        // R5 system reset
        if (i_rst) begin
            st_r <= '0;
            st_r.count <= clock_timer_pkg::COUNT_RESET;
            st_r.flags <= clock_timer_pkg::FLAGS_RESET;
            st_r.enable <= clock_timer_pkg::ENABLE_RESET;
            st_r.div <= clock_timer_pkg::DIV_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_tick_256hz = st_r.tick;
    assign link.irq_req = st_r.irq;
endmodule : clock_timer
`default_nettype wire

// >>> core/clock_timer_pkg.sv
package clock_timer_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [15:0] CTL_ADDR = 16'h5000;
    localparam logic [15:0] CNT_ADDR = 16'h5001;
    localparam logic [15:0] ENA_ADDR = 16'h5002;
    localparam logic [15:0] PND_ADDR = 16'h5003;
    // field positions
    localparam int RUN_BIT = 0;
    localparam int CLEAR_BIT = 4;
    // counter bit positions of the interrupt taps
    localparam int TAP_32HZ = 2;
    localparam int TAP_8HZ = 4;
    localparam int TAP_2HZ = 6;
    localparam int TAP_1HZ = 7;
    // values after reset
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    // operating tick divider on the low-speed oscillator
    localparam int TICK_DIVIDE = 128;
    localparam logic [6:0] DIV_RESET = 7'h00;
endpackage : clock_timer_pkg

// >>> core/clock_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface clock_timer_if;
    // shared level request toward the interrupt controller
    logic irq_req;
    modport device (output irq_req);
    modport controller (input irq_req);
endinterface : clock_timer_if
`default_nettype wire

// >>> core/timer_irq_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module timer_irq_receiver (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // controller side enable
    input wire logic i_controller_timer_enable,
    // pending level and request to the core
    output logic o_controller_timer_flag,
    output logic o_core_request,
    // link
    clock_timer_if.controller link
);
    typedef struct packed {
        logic flag;
        logic req;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        // R17 level: pending follows the block's request
        st_nxt.flag = link.irq_req;
        // R19 core vectors the request to entry 7
        st_nxt.req = link.irq_req && i_controller_timer_enable;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_controller_timer_flag = st_r.flag;
    assign o_core_request = st_r.req;
endmodule : timer_irq_receiver
`default_nettype wire

// >>> tb/clock_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module clock_timer_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // shared request and controller side
    input wire logic i_irq_req,
    input wire logic i_timer_flag,
    input wire logic i_core_request,
    input wire logic i_timer_enable,
    // register port and tick
    input wire logic [15:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_rdata,
    input wire logic i_tick
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    property p_copy;
        1'b1 |=> i_timer_flag == $past(i_irq_req);
    endproperty
    a_copy: assert property (p_copy)
        else $error("pending level not a copy of the request");
    property p_core;
        1'b1 |=> i_core_request == $past(i_irq_req & i_timer_enable);
    endproperty
    a_core: assert property (p_core)
        else $error("core request not the gated request");
    property p_tick_steady;
        $changed(i_tick) |=> $stable(i_tick) [*8];
    endproperty
    a_tick_steady: assert property (p_tick_steady)
        else $error("tick changed again too soon");
    property p_rdata_idle;
        !i_rd |=> i_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero without a read");
    property p_irq_at_tick;
        $rose(i_irq_req) |-> $past(i_tick, 2) && !$past(i_tick);
    endproperty
    a_irq_at_tick: assert property (p_irq_at_tick)
        else $error("request rose away from a tick fall");
    property p_irq_clear;
        $fell(i_irq_req) |-> $past(i_wr) && ($past(i_addr) == clock_timer_pkg::PND_ADDR);
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("request fell without a pending write");
endmodule : clock_timer_monitor
`default_nettype wire

// >>> tb/clock_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_timer_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic osc = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ena = 1'b1;
    logic [7:0] rdata;
    logic tick;
    logic flag;
    logic req;
    int miscompares = 0;
    int cmp_count = 0;
    clock_timer_if lk ();
    clock_timer clock_timer_i (.i_clk(i_clk), .i_rst(i_rst), .i_low_speed_oscillator(osc),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_tick_256hz(tick), .link(lk.device));
    timer_irq_receiver timer_irq_receiver_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_controller_timer_enable(ena), .o_controller_timer_flag(flag),
        .o_core_request(req), .link(lk.controller));
    clock_timer_monitor clock_timer_monitor_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_irq_req(lk.irq_req), .i_timer_flag(flag), .i_core_request(req),
        .i_timer_enable(ena), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_rdata(rdata),
        .i_tick(tick));
    always #12.5 i_clk = ~i_clk;
    // oscillator at half the clock rate: one tick is 256 clocks, keeps the run short
    always @(posedge i_clk) osc <= ~osc;
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp, input string nm);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 chk(nm, rdata, exp);
    endtask : rd_reg
    // waits for n tick falls, then lets the counter settle
    task automatic ticks(input int n);
        int k;
        repeat (n) begin
            k = 0;
            while (tick !== 1'b1 && k < 600) begin
                @(posedge i_clk);
                k++;
            end
            while (tick !== 1'b0 && k < 1200) begin
                @(posedge i_clk);
                k++;
            end
            if (k >= 1200) begin
                miscompares++;
                give_verdict();
            end
        end
        repeat (8) @(posedge i_clk);
    endtask : ticks
    task automatic t_reset;
        rd_reg(16'h5001, 8'h00, "count");
        rd_reg(16'h5000, 8'h00, "control");
        rd_reg(16'h5003, 8'h00, "pending");
        rd_reg(16'h5004, 8'h00, "unmapped");
        wr_reg(16'h5002, 8'hff);
        rd_reg(16'h5002, 8'h0f, "enable");
        wr_reg(16'h5002, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_run;
        wr_reg(16'h5000, 8'h11);
        ticks(6);
        rd_reg(16'h5001, 8'h05, "count");
        wr_reg(16'h5000, 8'h00);
        rd_reg(16'h5000, 8'h01, "run");
        ticks(3);
        rd_reg(16'h5001, 8'h06, "count");
        rd_reg(16'h5000, 8'h00, "run");
        wr_reg(16'h5000, 8'h01);
        ticks(2);
        rd_reg(16'h5001, 8'h07, "count");
        wr_reg(16'h5000, 8'h00);
        ticks(1);
        wr_reg(16'h5000, 8'h10);
        rd_reg(16'h5001, 8'h00, "count");
        rd_reg(16'h5000, 8'h00, "control");
        ticks(1);
        rd_reg(16'h5001, 8'h00, "count");
        $display("run test done");
    endtask : t_run
    task automatic t_irq;
        wr_reg(16'h5003, 8'h0f);
        wr_reg(16'h5002, 8'h08);
        wr_reg(16'h5000, 8'h11);
        ticks(8);
        rd_reg(16'h5003, 8'h00, "pending");
        ticks(1);
        rd_reg(16'h5003, 8'h08, "pending");
        chk("irq", {7'h00, lk.irq_req}, 8'h01);
        chk("core", {7'h00, req}, 8'h01);
        wr_reg(16'h5003, 8'h08);
        rd_reg(16'h5003, 8'h00, "pending");
        chk("irq", {7'h00, lk.irq_req}, 8'h00);
        wr_reg(16'h5002, 8'h04);
        ticks(24);
        rd_reg(16'h5003, 8'h04, "pending");
        wr_reg(16'h5000, 8'h11);
        ticks(2);
        rd_reg(16'h5001, 8'h02, "count");
        $display("irq test done");
    endtask : t_irq
    // slow taps with the controller side disabled
    task automatic t_slow;
        @(posedge i_clk);
        ena <= 1'b0;
        wr_reg(16'h5003, 8'h0f);
        wr_reg(16'h5002, 8'h03);
        wr_reg(16'h5000, 8'h11);
        ticks(128);
        rd_reg(16'h5003, 8'h02, "pending");
        chk("ctl flag", {7'h00, flag}, 8'h01);
        chk("core", {7'h00, req}, 8'h00);
        wr_reg(16'h5003, 8'h02);
        ticks(128);
        rd_reg(16'h5003, 8'h03, "pending");
        rd_reg(16'h5001, 8'h00, "count");
        $display("slow tap test done");
    endtask : t_slow
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_run();
        t_irq();
        t_slow();
        give_verdict();
    end
endmodule : clock_timer_tb
`default_nettype wire
